// File: design/msh_pkg.sv
// Package with constants for the modem serial host interface
package msh_pkg;
  // ==========================================================
  // Frame
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned CNT_W      = 5;
  localparam logic [4:0]  CNT_LAST   = 5'h18;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned SCLK_MAX_KHZ    = 12500;
  localparam int unsigned SCLK_MIN_CYCLES = (CLK_MHZ * 1000) / SCLK_MAX_KHZ;
  // ==========================================================
  // Reset values
  localparam logic [23:0] WORD_RST  = 24'h000000;
  localparam logic [7:0]  MASK_RST  = 8'h00;
  localparam logic [1:0]  IRQ_CFG_RST = 2'h0;
  localparam logic [2:0]  PIN_RST   = 3'h6; // Pins idle: select high, serial clock high, data low
  // ==========================================================
  // Interrupt config fields
  localparam int unsigned IRQ_CFG_EDGE = 0;
  localparam int unsigned IRQ_CFG_POS  = 1;
  // ==========================================================
  // Clock scheme codes
  localparam logic [1:0] CS_XTAL_FWD = 2'h0;
  localparam logic [1:0] CS_INT_FWD  = 2'h1;
  localparam logic [1:0] CS_EXT      = 2'h2;
  localparam logic [1:0] CS_INT      = 2'h3;
endpackage

// File: design/msh_sync.sv
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module msh_sync #(
  parameter int unsigned  W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  always_comb
  begin
    nxt_meta = din;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_ff <= RST;
      sync_ff <= RST;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign dout = sync_ff;
endmodule // msh_sync
`default_nettype wire

// File: design/msh_host_if.sv
// Serial host interface of the modem: framing, shifting, interrupt, straps
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Input bits are shifted in only while chip select is low.
// - With chip select high the data output floats and input activity is ignored.
// - Input bits are captured on the first 24 falling serial clock edges of a frame into a 24-bit register.
// - Output data changes on rising edges so it is valid at the falling edge.
// - Reset low powers the block down and clears all state; high resumes.
// - The interrupt pin can be edge or level type, positive or negative polarity.
// - Only events enabled in the mask may raise the interrupt.
// - A low oscillator-disable strap enables the crystal oscillator, high disables it.
// - With internal or crystal clock the clock pin may forward the running clock.
// - The clock scheme comes from the two clock strap levels together.
// - A high reference strap enables the internal reference, low selects external.
// - A high filter strap enables the internal filter, low bypasses it.
module msh_host_if (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Serial pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        sdi,
  output logic             sdo_o,
  output logic             sdo_oe_n,
  // Words to and from the core
  input  wire logic [23:0] tx_word,
  output logic      [23:0] rx_word,
  output logic             rx_valid,
  output logic             frame_err,
  // Interrupt
  input  wire logic [7:0]  event_in,
  input  wire logic [7:0]  irq_mask,
  input  wire logic [1:0]  irq_cfg,
  output logic             irq,
  // Straps and clock
  input  wire logic        crystal_osc_disable_strap,
  input  wire logic        clock_scheme_strap0,
  input  wire logic        clock_scheme_strap1,
  input  wire logic        ref_select_strap,
  input  wire logic        internal_filter_select,
  input  wire logic        clk_out_enable,
  input  wire logic        run_clock,
  output logic             forwarded_clock_pin,
  output logic             crystal_osc_enable,
  output logic             internal_osc_select,
  output logic             internal_ref_enable,
  output logic             internal_filter_enable,
  output logic             powered_up
);
  // ==========================================================
  // Pin synchronisers
  logic [2:0] pin_s;
  logic [4:0] strap_s;
  msh_sync #(.W(3), .RST(msh_pkg::PIN_RST)) u_pin_sync (.clk(clk), .rstn(rstn),
    .din({cs_n, sclk, sdi}), .dout(pin_s)); // Idle reset value avoids a false select edge
  msh_sync #(.W(5)) u_strap_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  ({crystal_osc_disable_strap, clock_scheme_strap1, clock_scheme_strap0,
            ref_select_strap, internal_filter_select}),
    .dout (strap_s)
  );
  logic cs_s;
  logic sclk_s;
  logic sdi_s;
  assign cs_s   = pin_s[2];
  assign sclk_s = pin_s[1];
  assign sdi_s  = pin_s[0];
  // ==========================================================
  // Serial engine
  logic        sclk_d_ff;
  logic        cs_d_ff;
  logic [23:0] shift_ff;
  logic [23:0] tx_sh_ff;
  logic [4:0]  cnt_ff;
  logic        sdo_ff;
  logic        oe_n_ff;
  logic [23:0] rx_word_ff;
  logic        rx_valid_ff;
  logic        err_ff;
  logic        nxt_sclk_d;
  logic        nxt_cs_d;
  logic [23:0] nxt_shift;
  logic [23:0] nxt_tx_sh;
  logic [4:0]  nxt_cnt;
  logic        nxt_sdo;
  logic        nxt_oe_n;
  logic [23:0] nxt_rx_word;
  logic        nxt_rx_valid;
  logic        nxt_err;
  logic        fall;
  logic        rise;
  logic        cs_fall;
  logic        cs_rise;
  assign fall    = sclk_d_ff & ~sclk_s;
  assign rise    = ~sclk_d_ff & sclk_s;
  assign cs_fall = cs_d_ff & ~cs_s;
  assign cs_rise = ~cs_d_ff & cs_s;
  always_comb
  begin
    nxt_sclk_d   = sclk_s;
    nxt_cs_d     = cs_s;
    nxt_shift    = shift_ff;
    nxt_tx_sh    = tx_sh_ff;
    nxt_cnt      = cnt_ff;
    nxt_sdo      = sdo_ff;
    nxt_oe_n     = cs_s;
    nxt_rx_word  = rx_word_ff;
    nxt_rx_valid = 1'b0;
    nxt_err      = 1'b0;
    if (cs_fall)
    begin
      nxt_cnt   = 5'h00;
      nxt_tx_sh = {tx_word[22:0], 1'b0};
      nxt_sdo   = tx_word[23];
    end
    else if (!cs_s)
    begin
      if (fall && cnt_ff != msh_pkg::CNT_LAST)
      begin
        nxt_shift = {shift_ff[22:0], sdi_s};
        nxt_cnt   = cnt_ff + 5'h01;
      end
      if (rise && cnt_ff != 5'h00)
      begin
        nxt_sdo   = tx_sh_ff[23];
        nxt_tx_sh = {tx_sh_ff[22:0], 1'b0};
      end
    end
    if (cs_rise)
    begin
      if (cnt_ff == msh_pkg::CNT_LAST)
      begin
        nxt_rx_word  = shift_ff;
        nxt_rx_valid = 1'b1;
      end
      else
      begin
        nxt_err = 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclk_d_ff   <= 1'b0;
      cs_d_ff     <= 1'b1;
      shift_ff    <= msh_pkg::WORD_RST;
      tx_sh_ff    <= msh_pkg::WORD_RST;
      cnt_ff      <= 5'h00;
      sdo_ff      <= 1'b0;
      oe_n_ff     <= 1'b1;
      rx_word_ff  <= msh_pkg::WORD_RST;
      rx_valid_ff <= 1'b0;
      err_ff      <= 1'b0;
    end
    else
    begin
      sclk_d_ff   <= nxt_sclk_d;
      cs_d_ff     <= nxt_cs_d;
      shift_ff    <= nxt_shift;
      tx_sh_ff    <= nxt_tx_sh;
      cnt_ff      <= nxt_cnt;
      sdo_ff      <= nxt_sdo;
      oe_n_ff     <= nxt_oe_n;
      rx_word_ff  <= nxt_rx_word;
      rx_valid_ff <= nxt_rx_valid;
      err_ff      <= nxt_err;
    end
  end
  assign sdo_o     = sdo_ff;
  assign sdo_oe_n  = oe_n_ff;
  assign rx_word   = rx_word_ff;
  assign rx_valid  = rx_valid_ff;
  assign frame_err = err_ff;
  // ==========================================================
  // Interrupt
  logic       irq_ff;
  logic       act_d_ff;
  logic       nxt_irq;
  logic       nxt_act_d;
  logic       active;
  assign active = |(event_in & irq_mask);
  always_comb
  begin
    nxt_act_d = active;
    if (irq_cfg[msh_pkg::IRQ_CFG_EDGE])
      nxt_irq = (active & ~act_d_ff) ^ ~irq_cfg[msh_pkg::IRQ_CFG_POS];
    else
      nxt_irq = active ^ ~irq_cfg[msh_pkg::IRQ_CFG_POS];
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_ff   <= 1'b0;
      act_d_ff <= 1'b0;
    end
    else
    begin
      irq_ff   <= nxt_irq;
      act_d_ff <= nxt_act_d;
    end
  end
  assign irq = irq_ff;
  // ==========================================================
  // Straps and clock forwarding
  logic xo_ff;
  logic io_ff;
  logic ref_ff;
  logic flt_ff;
  logic fwd_ff;
  logic pwr_ff;
  logic nxt_xo;
  logic nxt_io;
  logic nxt_ref;
  logic nxt_flt;
  logic nxt_fwd;
  logic [1:0] scheme;
  assign scheme = strap_s[3:2];
  always_comb
  begin
    nxt_xo  = ~strap_s[4];
    nxt_io  = strap_s[4] & (scheme == msh_pkg::CS_INT_FWD || scheme == msh_pkg::CS_INT);
    nxt_ref = strap_s[1];
    nxt_flt = strap_s[0];
    nxt_fwd = 1'b0;
    if (clk_out_enable && scheme != msh_pkg::CS_EXT && (nxt_xo || nxt_io))
      nxt_fwd = run_clock;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      xo_ff  <= 1'b0;
      io_ff  <= 1'b0;
      ref_ff <= 1'b0;
      flt_ff <= 1'b0;
      fwd_ff <= 1'b0;
      pwr_ff <= 1'b0;
    end
    else
    begin
      xo_ff  <= nxt_xo;
      io_ff  <= nxt_io;
      ref_ff <= nxt_ref;
      flt_ff <= nxt_flt;
      fwd_ff <= nxt_fwd;
      pwr_ff <= 1'b1;
    end
  end
  assign crystal_osc_enable     = xo_ff;
  assign internal_osc_select    = io_ff;
  assign internal_ref_enable    = ref_ff;
  assign internal_filter_enable = flt_ff;
  assign forwarded_clock_pin    = fwd_ff;
  assign powered_up             = pwr_ff;
  // ==========================================================
  // Assertions
  a_oe_follows_cs: assert property (@(posedge clk) disable iff (!rstn)
    cs_s |=> sdo_oe_n) else $error("data output driven while deselected");
  a_no_shift_idle: assert property (@(posedge clk) disable iff (!rstn)
    cs_s && !cs_fall |=> $stable(shift_ff)) else $error("shift while deselected");
  a_shift_on_fall: assert property (@(posedge clk) disable iff (!rstn)
    !cs_s && !cs_fall && fall && cnt_ff < msh_pkg::CNT_LAST |=> shift_ff[0] == $past(sdi_s))
    else $error("bit not captured on falling edge");
  a_sdo_on_rise: assert property (@(posedge clk) disable iff (!rstn)
    !cs_s && fall |=> $stable(sdo_o)) else $error("output moved at falling edge");
  a_frame_done: assert property (@(posedge clk) disable iff (!rstn)
    cs_rise && cnt_ff == msh_pkg::CNT_LAST |=> rx_valid && rx_word == $past(shift_ff))
    else $error("full frame not delivered");
  a_frame_short: assert property (@(posedge clk) disable iff (!rstn)
    cs_rise && cnt_ff != msh_pkg::CNT_LAST |=> frame_err && !rx_valid)
    else $error("short frame not flagged");
  a_irq_masked: assert property (@(posedge clk) disable iff (!rstn)
    (event_in & irq_mask) == 8'h00 ##1 (event_in & irq_mask) == 8'h00
    |=> irq == ~irq_cfg[1]) else $error("masked event raised interrupt");
  a_irq_level: assert property (@(posedge clk) disable iff (!rstn)
    !irq_cfg[0] && $stable(irq_cfg) |=> (irq == $past(irq_cfg[1])) == $past(active))
    else $error("level interrupt wrong");
  a_strap_map: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> crystal_osc_enable == !$past(strap_s[4]) && internal_ref_enable == $past(strap_s[1])
    && internal_filter_enable == $past(strap_s[0])) else $error("strap mapping wrong");
  a_fwd_gated: assert property (@(posedge clk) disable iff (!rstn)
    !clk_out_enable |=> !forwarded_clock_pin) else $error("clock forwarded while off");
  c_full_frame: cover property (@(posedge clk) disable iff (!rstn) rx_valid);
  c_short_frame: cover property (@(posedge clk) disable iff (!rstn) frame_err);
  c_irq_edge: cover property (@(posedge clk) disable iff (!rstn) irq_cfg[0] && irq);
endmodule // msh_host_if
`default_nettype wire

// File: tb/msh_host_model.sv
// Host serial master model that drives frames into the interface
`timescale 1ns/1ps
`default_nettype none
module msh_host_model (
  // Serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo_o,
  input  wire logic sdo_oe_n
);
  // ==========================================================
  // Link timing, 80 ns period
  localparam time HALF = 40;
  logic sdo_line;
  assign sdo_line = sdo_oe_n ? ~sdo_o : sdo_o; // Undriven line reads inverted to catch a late enable
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b1;
    sdi  = 1'b0;
  end
  // ==========================================================
  // One frame of nbits clocks; sel low leaves select idle
  task automatic xfer(input logic sel, input logic [23:0] tx, input int nbits,
                      output logic [23:0] rx);
    rx = 24'h000000;
    cs_n = ~sel;
    #(2*HALF);
    for (int i = 0; i < nbits; i++)
    begin
      sdi = tx[23-i];
      #HALF sclk = 1'b0;
      rx = {rx[22:0], sdo_line};
      #HALF sclk = 1'b1;
    end
    #HALF cs_n = 1'b1;
    sdi = ~sdi;
    #(2*HALF);
  endtask
endmodule // msh_host_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking testbench for the modem serial host interface
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk, rstn, cs_n, sclk, sdi, sdo_o, sdo_oe_n;
  logic [23:0] tx_word, rx_word, rx;
  logic        rx_valid, frame_err, irq, fwd, xo_en, io_sel, ref_en, flt_en, pwr;
  logic [7:0]  event_in, irq_mask;
  logic [1:0]  irq_cfg;
  logic        osc_dis, cs0, cs1, ref_sel, flt_sel, clk_out_enable, run_clock;
  int          num_errors, comparisons, n_ok, n_bad, n_irq;
  // ==========================================================
  // Design and host
  msh_host_if i_dut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .tx_word(tx_word), .rx_word(rx_word),
    .rx_valid(rx_valid), .frame_err(frame_err), .event_in(event_in),
    .irq_mask(irq_mask), .irq_cfg(irq_cfg), .irq(irq),
    .crystal_osc_disable_strap(osc_dis), .clock_scheme_strap0(cs0),
    .clock_scheme_strap1(cs1), .ref_select_strap(ref_sel),
    .internal_filter_select(flt_sel), .clk_out_enable(clk_out_enable),
    .run_clock(run_clock), .forwarded_clock_pin(fwd), .crystal_osc_enable(xo_en),
    .internal_osc_select(io_sel), .internal_ref_enable(ref_en),
    .internal_filter_enable(flt_en), .powered_up(pwr));
  msh_host_model i_host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo_o(sdo_o),
    .sdo_oe_n(sdo_oe_n));
  // ==========================================================
  // Clock and pulse monitors
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk)
  begin
    if (rx_valid === 1'b1) n_ok++;
    if (frame_err === 1'b1) n_bad++;
    if (irq === irq_cfg[1]) n_irq++;
  end
  // ==========================================================
  // Compare and closing tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({23'h0, got}, {23'h0, exp});
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    num_errors++;
    end_sim();
  end
  // ==========================================================
  // Test sequence
  initial
  begin
    {rstn, tx_word, event_in, irq_mask, irq_cfg} = '0;
    {osc_dis, cs0, cs1, ref_sel, flt_sel, clk_out_enable, run_clock} = '0;
    {num_errors, comparisons, n_ok, n_bad, n_irq} = '0;
    repeat (16) @(negedge clk);
    chk1(sdo_oe_n, 1'b1);
    chk1(pwr, 1'b0);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk1(pwr, 1'b1);
    tx_word = 24'hA5C396;
    i_host.xfer(1'b1, 24'h3C5A69, 24, rx);
    chk(rx, 24'hA5C396);
    chk(rx_word, 24'h3C5A69);
    chk(24'(n_ok), 24'h000001);
    chk1(sdo_oe_n, 1'b1);
    i_host.xfer(1'b1, 24'hFFFFFF, 23, rx);
    chk(24'(n_bad), 24'h000001);
    chk(rx_word, 24'h3C5A69);
    i_host.xfer(1'b0, 24'h123456, 24, rx);
    chk(24'(n_ok + n_bad), 24'h000002);
    chk(rx_word, 24'h3C5A69);
    tx_word = 24'h0F00F1;
    i_host.xfer(1'b1, 24'h800001, 24, rx);
    chk(rx, 24'h0F00F1);
    chk(rx_word, 24'h800001);
    for (int c = 0; c < 4; c++)
    begin
      irq_cfg = 2'(c);
      irq_mask = 8'h01;
      event_in = 8'h00;
      repeat (4) @(negedge clk);
      chk1(irq, ~irq_cfg[1]);
      event_in = 8'h02;
      repeat (4) @(negedge clk);
      chk1(irq, ~irq_cfg[1]);
      n_irq = 0;
      event_in = 8'h03;
      repeat (8) @(negedge clk);
      if (irq_cfg[0]) chk(24'(n_irq), 24'h000001);
      else chk1(irq, irq_cfg[1]);
    end
    for (int s = 0; s < 64; s++)
    begin
      {clk_out_enable, flt_sel, ref_sel, cs1, cs0, osc_dis} = 6'(s);
      run_clock = 1'b1;
      repeat (6) @(negedge clk);
      chk1(xo_en, ~osc_dis);
      chk1(io_sel, osc_dis & cs0);
      chk1(ref_en, ref_sel);
      chk1(flt_en, flt_sel);
      chk1(fwd, clk_out_enable & (~osc_dis | cs0) & ~(cs1 & ~cs0));
      run_clock = 1'b0;
      repeat (2) @(negedge clk);
      chk1(fwd, 1'b0);
    end
    rstn = 1'b0;
    @(negedge clk);
    chk(rx_word, 24'h000000);
    chk1(pwr, 1'b0);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk1(sdo_oe_n, 1'b1);
    chk(24'(n_bad), 24'h000001);
    tx_word = 24'h5A5A0F;
    i_host.xfer(1'b1, 24'hC30FF0, 24, rx);
    chk(rx, 24'h5A5A0F);
    chk(rx_word, 24'hC30FF0);
    chk(24'(n_ok), 24'h000003);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
